// >>> bmc_codec.sv
// Purpose: bmc bit encoder and edge-interval decoder for one line
// Assumes: line_in already synchronised
// Notes: shared by both ends
`timescale 1ns/1ns
`default_nettype none
module bmc_codec (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // transmit
  input wire logic tx_start_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic line_out_out,
  output logic line_oe_out,
  output logic tx_busy_out,
  // receive
  input wire logic line_in,
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic idle_out
);
  // ------------------------------------------------------------
  // transmit
  // ------------------------------------------------------------
  bmc_pkg::tx_state_t st_q, st_d;
  logic [bmc_pkg::CNT_W-1:0] tc_q, tc_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bc_q, bc_d;
  logic last_q, last_d, lvl_q, lvl_d;
  assign tx_ready_out = (st_q == bmc_pkg::TX_IDLE) ||
                        (st_q == bmc_pkg::TX_BITS && tc_q == bmc_pkg::UI_CNT - bmc_pkg::CNT_ONE
                         && bc_q == 3'h7 && !last_q);
  // encoder next state
  always_comb begin
    st_d = st_q;
    tc_d = tc_q + bmc_pkg::CNT_ONE;
    sh_d = sh_q;
    bc_d = bc_q;
    last_d = last_q;
    lvl_d = lvl_q;
    unique case (st_q)
      bmc_pkg::TX_IDLE: begin
        tc_d = bmc_pkg::CNT_ZERO;
        if (tx_start_in) begin
          st_d = bmc_pkg::TX_LEAD;
          lvl_d = 1'b0;
          sh_d = tx_data_in;
          last_d = tx_last_in;
          bc_d = 3'h0;
        end
      end
      bmc_pkg::TX_LEAD: begin
        if (tc_q == bmc_pkg::HALF_CNT) begin
          st_d = bmc_pkg::TX_BITS;
          tc_d = bmc_pkg::CNT_ZERO;
          lvl_d = ~lvl_q;
        end
      end
      bmc_pkg::TX_BITS: begin
        if (tc_q == bmc_pkg::HALF_CNT && sh_q[0]) begin
          lvl_d = ~lvl_q;
        end
        if (tc_q == bmc_pkg::UI_CNT - bmc_pkg::CNT_ONE) begin
          tc_d = bmc_pkg::CNT_ZERO;
          lvl_d = ~lvl_q;
          bc_d = bc_q + 3'h1;
          sh_d = {1'b0, sh_q[7:1]};
          if (bc_q == 3'h7) begin
            if (last_q) begin
              st_d = bmc_pkg::TX_TAIL;
            end else if (tx_start_in) begin
              sh_d = tx_data_in;
              last_d = tx_last_in;
            end else begin
              st_d = bmc_pkg::TX_TAIL;
            end
          end
        end
      end
      bmc_pkg::TX_TAIL: begin
        if (tc_q == bmc_pkg::HALF_CNT) begin
          st_d = bmc_pkg::TX_IDLE;
        end
      end
    endcase
  end
  // encoder registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= bmc_pkg::TX_IDLE;
      tc_q <= bmc_pkg::CNT_ZERO;
      sh_q <= 8'h00;
      bc_q <= 3'h0;
      last_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tc_q <= tc_d;
      sh_q <= sh_d;
      bc_q <= bc_d;
      last_q <= last_d;
      lvl_q <= lvl_d;
    end
  end
  assign line_out_out = lvl_q;
  assign line_oe_out = (st_q != bmc_pkg::TX_IDLE);
  assign tx_busy_out = line_oe_out;
  // ------------------------------------------------------------
  // receive
  // ------------------------------------------------------------
  logic prev_q, prev_d, half_q, half_d, rv_q, rv_d, rb_q, rb_d, idle_q, idle_d;
  logic [bmc_pkg::CNT_W-1:0] rc_q, rc_d;
  // interval decoder, first edge only starts timing
  always_comb begin
    prev_d = line_in;
    rc_d = (rc_q == bmc_pkg::IDLE_CNT) ? rc_q : rc_q + bmc_pkg::CNT_ONE;
    half_d = half_q;
    rv_d = 1'b0;
    rb_d = rb_q;
    idle_d = (rc_q == bmc_pkg::IDLE_CNT);
    if (line_in != prev_q) begin
      rc_d = bmc_pkg::CNT_ZERO;
      idle_d = 1'b0;
      if (rc_q == bmc_pkg::IDLE_CNT) begin
        half_d = 1'b0;
      end else if (rc_q >= bmc_pkg::SPLIT_CNT) begin
        rv_d = 1'b1;
        rb_d = 1'b0;
        half_d = 1'b0;
      end else if (half_q) begin
        rv_d = 1'b1;
        rb_d = 1'b1;
        half_d = 1'b0;
      end else begin
        half_d = 1'b1;
      end
    end
  end
  // decoder registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev_q <= 1'b1;
      rc_q <= bmc_pkg::IDLE_CNT;
      half_q <= 1'b0;
      rv_q <= 1'b0;
      rb_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
      rc_q <= rc_d;
      half_q <= half_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      idle_q <= idle_d;
    end
  end
  assign rx_valid_out = rv_q;
  assign rx_bit_out = rb_q;
  assign idle_out = idle_q;
endmodule : bmc_codec
`default_nettype wire

// >>> bmc_pkg.sv
// Purpose: shared constants and types for the bmc phy and its partner end
// Assumes: 100 MHz clock, 300 kbit/s nominal bmc rate
// Notes: timing counts derive from the unit interval
package bmc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int UI_NS = 3340;
  localparam int UI_CYC = (UI_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_CYC = UI_CYC / 2;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] UI_CNT = CNT_W'(UI_CYC);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC);
  localparam logic [CNT_W-1:0] SPLIT_CNT = CNT_W'((UI_CYC * 3) / 4);
  localparam logic [CNT_W-1:0] IDLE_CNT = CNT_W'(UI_CYC * 3);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LEAD = 2'b01,
    TX_BITS = 2'b10,
    TX_TAIL = 2'b11
  } tx_state_t;
endpackage : bmc_pkg

// >>> cc_wire_if.sv
// Purpose: the two-pin configuration channel shared by both ends
// Assumes: the device gives level and enable per pin, the partner one level and enable plus a pin select
// Notes: wire level resolves from enables; undriven reads high as bias
`timescale 1ns/1ns
`default_nettype none
interface cc_wire_if;
  logic dev_a_out, dev_a_oe, dev_b_out, dev_b_oe;
  logic far_out, far_oe;
  logic far_pin_b;
  logic pin_a, pin_b;
  // resolve pin levels
  assign pin_a = dev_a_oe ? dev_a_out : ((far_oe && !far_pin_b) ? far_out : 1'b1);
  assign pin_b = dev_b_oe ? dev_b_out : ((far_oe && far_pin_b) ? far_out : 1'b1);
  modport device (output dev_a_out, dev_a_oe, dev_b_out, dev_b_oe, input pin_a, pin_b);
  modport partner (output far_out, far_oe, far_pin_b, input pin_a, pin_b);
endinterface : cc_wire_if
`default_nettype wire

// >>> pd_phy_asserts.sv
// Purpose: wire checks for the shared configuration channel
// Assumes: one clock, sync active-high reset
// Notes: sees only the interface signals
`timescale 1ns/1ns
`default_nettype none
module pd_phy_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // wire drivers
  input wire logic dev_a_out,
  input wire logic dev_a_oe,
  input wire logic dev_b_out,
  input wire logic dev_b_oe,
  input wire logic far_out,
  input wire logic far_oe,
  input wire logic far_pin_b
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic d_oe;
  logic d_o;
  // merged device drive
  assign d_oe = dev_a_oe | dev_b_oe;
  assign d_o = dev_a_oe ? dev_a_out : dev_b_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_one_pin: assert property (!(dev_a_oe && dev_b_oe))
    else $error("both pins driven");
  a_one_driver: assert property (!(d_oe && far_oe && (dev_b_oe == far_pin_b)))
    else $error("two drivers on wire");
  a_lead_low: assert property ($rose(d_oe) |-> !d_o [*8])
    else $error("device lead not low");
  a_far_lead: assert property ($rose(far_oe) |-> !far_out [*8])
    else $error("far lead not low");
  a_first_edge: assert property ($rose(d_oe) |-> ##[160:172] $changed(d_o))
    else $error("first bit edge missing");
  a_bit_gap: assert property (d_oe && $changed(d_o) |=> $stable(d_o) [*8])
    else $error("edges too close");
  a_edge_gap: assert property (d_oe && $changed(d_o) |-> ##[1:340] ($changed(d_o) || !d_oe))
    else $error("no edge within a bit");
  a_hold_after: assert property (d_oe && $changed(d_o) |=> d_oe [*8])
    else $error("device released after edge");
  a_far_hold: assert property (far_oe && $changed(far_out) |=> far_oe [*8])
    else $error("far released after edge");
endmodule : pd_phy_asserts
`default_nettype wire

// >>> pd_phy_device.sv
// Purpose: device-end bmc phy for one type-c port
// Assumes: orientation stable during a connection
// Notes: instantiate once per port
// What this block does
// - every bit starts with a line toggle
// - ones add a mid-bit toggle
// - preamble starts by driving low
// - receiver tolerates a lost first edge
// - closing edge ends the final bit
// - pin released when not sending
// - one pin per connection, never switching
// - data on the biased pin
// - start not held off while the far end drives the wire
// - squelch reports bus idle
// - one identical instance per port
`timescale 1ns/1ns
`default_nettype none
module pd_phy_device (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // wire
  cc_wire_if.device cc,
  // orientation, low selects pin a
  input wire logic orient_b_in,
  input wire logic attached_in,
  // transmit
  input wire logic tx_start_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic tx_busy_out,
  // receive
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic idle_out
);
  // ------------------------------------------------------------
  // orientation latch and pin sync
  // ------------------------------------------------------------
  logic sel_q, sel_d, lo, loe, busy;
  logic [1:0] s1_q, s1_d, s2_q, s2_d;
  // hold selection for the whole connection
  always_comb begin
    sel_d = sel_q;
    if (!attached_in && !busy) begin
      sel_d = orient_b_in;
    end
    // both pins pass two flops before the orientation mux reads them
    s1_d = {cc.pin_b, cc.pin_a};
    s2_d = s1_q;
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sel_q <= 1'b0;
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      sel_q <= sel_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  // codec, one per port
  bmc_codec codec (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tx_start_in(tx_start_in && attached_in),
    .tx_data_in(tx_data_in),
    .tx_last_in(tx_last_in),
    .tx_ready_out(tx_ready_out),
    .line_out_out(lo),
    .line_oe_out(loe),
    .tx_busy_out(busy),
    .line_in(sel_q ? s2_q[1] : s2_q[0]),
    .rx_valid_out(rx_valid_out),
    .rx_bit_out(rx_bit_out),
    .idle_out(idle_out)
  );
  // drive only the selected biased pin
  assign cc.dev_a_out = lo;
  assign cc.dev_b_out = lo;
  assign cc.dev_a_oe = loe && !sel_q;
  assign cc.dev_b_oe = loe && sel_q;
  assign tx_busy_out = busy;
endmodule : pd_phy_device
`default_nettype wire

// >>> pd_phy_partner.sv
// Purpose: far-end bmc port on the shared wire
// Assumes: pin choice fixed by plug
// Notes: mirrors the device codec
`timescale 1ns/1ns
`default_nettype none
module pd_phy_partner (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // wire
  cc_wire_if.partner cc,
  // plug side, high uses pin b
  input wire logic use_pin_b_in,
  // transmit
  input wire logic tx_start_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic tx_busy_out,
  // receive
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic idle_out
);
  logic lo, loe;
  logic [1:0] s1_q, s1_d, s2_q, s2_d;
  // two-flop sync of both pins, the plug choice muxes after it
  always_comb begin
    s1_d = {cc.pin_b, cc.pin_a};
    s2_d = s1_q;
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  bmc_codec codec (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tx_start_in(tx_start_in),
    .tx_data_in(tx_data_in),
    .tx_last_in(tx_last_in),
    .tx_ready_out(tx_ready_out),
    .line_out_out(lo),
    .line_oe_out(loe),
    .tx_busy_out(tx_busy_out),
    .line_in(use_pin_b_in ? s2_q[1] : s2_q[0]),
    .rx_valid_out(rx_valid_out),
    .rx_bit_out(rx_bit_out),
    .idle_out(idle_out)
  );
  assign cc.far_out = lo;
  assign cc.far_oe = loe;
  assign cc.far_pin_b = use_pin_b_in;
endmodule : pd_phy_partner
`default_nettype wire

// >>> usb_pd_bmc_phy_bench.sv
// Purpose: self-checking bench for both phy ends on one wire
// Assumes: 100 MHz clock, sync reset
// Notes: rows hold frames and their expected wire edge counts
`timescale 1ns/1ns
`default_nettype none
module usb_pd_bmc_phy_bench;
  typedef struct packed {
    logic dir;
    logic orn;
    logic two;
    logic [15:0] dat;
    logic [7:0] edg;
  } row_t;
  // dir low sends from the device end; edg counts lead, bit and closing edges
  localparam row_t ROWS [4] = '{'{1'b0, 1'b0, 1'b0, 16'h00A5, 8'h0E},
    '{1'b1, 1'b0, 1'b1, 16'h00FF, 8'h1A}, '{1'b0, 1'b1, 1'b1, 16'h3C01, 8'h17},
    '{1'b1, 1'b1, 1'b0, 16'h0000, 8'h0A}};
  logic clk_in, sys_rst_in, orn, use_b, att, ln, ln_q;
  logic [1:0] st, lt, rdy, bsy, vld, bt, idl;
  logic [7:0] dt [2];
  logic q0 [$];
  logic q1 [$];
  int err_count, checked, ecnt;
  cc_wire_if ifc ();
  pd_phy_device pd_phy_device_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cc(ifc),
    .orient_b_in(orn), .attached_in(att), .tx_start_in(st[0]), .tx_data_in(dt[0]),
    .tx_last_in(lt[0]), .tx_ready_out(rdy[0]), .tx_busy_out(bsy[0]),
    .rx_valid_out(vld[0]), .rx_bit_out(bt[0]), .idle_out(idl[0]));
  pd_phy_partner pd_phy_partner_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cc(ifc),
    .use_pin_b_in(use_b), .tx_start_in(st[1]), .tx_data_in(dt[1]), .tx_last_in(lt[1]),
    .tx_ready_out(rdy[1]), .tx_busy_out(bsy[1]), .rx_valid_out(vld[1]),
    .rx_bit_out(bt[1]), .idle_out(idl[1]));
  pd_phy_asserts pd_phy_asserts_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .dev_a_out(ifc.dev_a_out), .dev_a_oe(ifc.dev_a_oe), .dev_b_out(ifc.dev_b_out),
    .dev_b_oe(ifc.dev_b_oe), .far_out(ifc.far_out), .far_oe(ifc.far_oe),
    .far_pin_b(ifc.far_pin_b));
  // ----------------------------------------
  // monitors and tasks
  // ----------------------------------------
  assign ln = use_b ? ifc.pin_b : ifc.pin_a;
  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // count driven edges and collect decoded bits
  always @(posedge clk_in) begin
    ln_q <= ln;
    if ((ifc.dev_a_oe | ifc.dev_b_oe | ifc.far_oe) === 1'b1 && ln !== ln_q) ecnt++;
    if (vld[0] === 1'b1) q0.push_back(bt[0]);
    if (vld[1] === 1'b1) q1.push_back(bt[1]);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // send one frame from end s and check the far receiver
  task automatic run(input int s, input logic [15:0] dat, input logic two, input logic [7:0] edg);
    int n;
    int nb;
    logic rq [$];
    @(posedge clk_in);
    q0.delete();
    q1.delete();
    ecnt = 0;
    for (int k = 0; k <= int'(two); k++) begin
      st[s] <= 1'b1;
      dt[s] <= dat[k*8 +: 8];
      lt[s] <= (k == int'(two));
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (rdy[s] !== 1'b1 && n < 3000);
      chk(32'(n < 3000), 32'h1);
    end
    st[s] <= 1'b0;
    repeat (2) @(posedge clk_in);
    n = 0;
    while ((bsy[s] !== 1'b0 || idl[1-s] !== 1'b1) && n < 6000) begin
      @(posedge clk_in);
      n++;
    end
    chk(32'(n < 6000), 32'h1);
    chk(ecnt, 32'(edg));
    if (s == 0) rq = q1;
    else rq = q0;
    nb = 8 + 8 * int'(two);
    chk(32'(rq.size()), 32'(nb));
    for (int k = 0; k < nb; k++) chk(32'(rq[rq.size() - nb + k]), 32'(dat[k]));
    chk({ifc.dev_a_oe, ifc.dev_b_oe, ifc.far_oe}, 32'h0);
  endtask : run
  // watchdog
  initial begin
    #600_000;
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    orn = 1'b0;
    use_b = 1'b0;
    att = 1'b0;
    st = 2'b00;
    lt = 2'b00;
    dt[0] = 8'h00;
    dt[1] = 8'h00;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge clk_in);
      att <= 1'b0;
      orn <= ROWS[i].orn;
      use_b <= ROWS[i].orn;
      @(posedge clk_in);
      att <= 1'b1;
      run(int'(ROWS[i].dir), ROWS[i].dat, ROWS[i].two, ROWS[i].edg);
    end
    // orientation change ignored while attached
    @(posedge clk_in);
    att <= 1'b0;
    orn <= 1'b0;
    use_b <= 1'b0;
    @(posedge clk_in);
    att <= 1'b1;
    @(posedge clk_in);
    orn <= 1'b1;
    run(0, 16'h005A, 1'b0, 8'h0E);
    // start refused while detached
    att <= 1'b0;
    @(posedge clk_in);
    st[0] <= 1'b1;
    repeat (20) @(posedge clk_in);
    chk({bsy[0], ifc.dev_a_oe, ifc.dev_b_oe}, 32'h0);
    st[0] <= 1'b0;
    // reset in mid-lead releases the pin at once, then a frame goes through
    orn <= 1'b0;
    use_b <= 1'b0;
    @(posedge clk_in);
    att <= 1'b1;
    st[0] <= 1'b1;
    repeat (50) @(posedge clk_in);
    chk({bsy[0], ifc.dev_a_oe}, 32'h3);
    st[0] <= 1'b0;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk({rdy[0], bsy[0], ifc.dev_a_oe, idl[1]}, 32'h9);
    sys_rst_in <= 1'b0;
    run(0, 16'h00C3, 1'b0, 8'h0E);
    close_out();
  end
endmodule : usb_pd_bmc_phy_bench
`default_nettype wire
